// ===== hdl/sfpi_consts.vh
/*
  Shared constants of the serial flash pin interface: phase modes,
  synchroniser width and pin positions, buffer shape and idle values.
  Assumes it is included by bare name from the design files under hdl/.
*/
`ifndef SFPI_CONSTS_VH
`define SFPI_CONSTS_VH

// Phase modes, chosen per byte by the command logic
`define SFPI_MODE_SIN 2'h0
`define SFPI_MODE_SOUT 2'h1
`define SFPI_MODE_DOUT 2'h2
`define SFPI_MODE_DIN 2'h3

// Pin synchroniser
`define SFPI_SYNC_W 6
`define SFPI_PIN_SEL 0
`define SFPI_PIN_SCLK 1
`define SFPI_PIN_PRI 2
`define SFPI_PIN_SEC 3
`define SFPI_PIN_HOLD 4
`define SFPI_PIN_WP 5

// Receive buffer: first-byte flag plus one data byte
`define SFPI_RX_W 9
`define SFPI_RX_DEPTH 32
`define SFPI_RX_AW 5

// Byte layout and idle values
`define SFPI_BYTE_BITS 4'h8
`define SFPI_TX_IDLE 8'hff
`define SFPI_BP_RST 3'h0

`endif

// ===== hdl/sfpi_fifo.v
/*
  Synchronous FIFO with valid and ready on both sides.
  Flags and the head word are registered so a top level can drive
  them straight out. Assumes one clock and DEPTH a power of two.
*/
module sfpi_fifo #(
  parameter W = 9,
  parameter DEPTH = 32,
  parameter AW = 5
) (
  input wire sys_clk, // System clock
  input wire rst_b, // Synchronous reset, active low
  input wire [W-1:0] in_data, // Word to store
  input wire in_valid, // Word offered
  output reg in_ready, // Room for a word
  output reg [W-1:0] out_data, // Head word
  output reg out_valid, // Head word present
  input wire out_ready // Head word taken
);

  reg [W-1:0] mem [0:DEPTH-1];
  reg [AW-1:0] wr_ptr_r;
  reg [AW-1:0] rd_ptr_r;
  reg [AW:0] cnt_r;
  wire wr_en = in_valid & in_ready;
  wire rd_en = out_valid & out_ready;
  wire [AW-1:0] rd_nxt = rd_en ? rd_ptr_r + 1'b1 : rd_ptr_r;
  wire [AW:0] cnt_nxt = cnt_r + {{AW{1'b0}}, wr_en} - {{AW{1'b0}}, rd_en};

  always @(posedge sys_clk)
  begin
    if (wr_en)
      mem[wr_ptr_r] <= in_data;
  end

  always @(posedge sys_clk)
  begin
    if (!rst_b)
    begin
      wr_ptr_r <= {AW{1'b0}};
      rd_ptr_r <= {AW{1'b0}};
      cnt_r <= {(AW+1){1'b0}};
      in_ready <= 1'b0;
      out_valid <= 1'b0;
      out_data <= {W{1'b0}};
    end
    else
    begin
      if (wr_en)
        wr_ptr_r <= wr_ptr_r + 1'b1;
      rd_ptr_r <= rd_nxt;
      cnt_r <= cnt_nxt;
      in_ready <= (cnt_nxt != DEPTH);
      out_valid <= (cnt_nxt != {(AW+1){1'b0}});
      // Bypass the array when the new head is written this very cycle
      if (wr_en && wr_ptr_r == rd_nxt)
        out_data <= in_data;
      else
        out_data <= mem[rd_nxt];
    end
  end

endmodule

// ===== hdl/sfpi_sync.v
/*
  Two-stage synchroniser for a bundle of pin levels.
  Assumes each bit is an independent level from outside sys_clk.
*/
module sfpi_sync #(
  parameter W = 1
) (
  input wire sys_clk, // System clock
  input wire rst_b, // Synchronous reset, active low
  input wire [W-1:0] d, // Asynchronous levels
  output reg [W-1:0] q // Synchronised levels
);

  reg [W-1:0] meta_r;

  always @(posedge sys_clk)
  begin
    if (!rst_b)
    begin
      meta_r <= {W{1'b1}};
      q <= {W{1'b1}};
    end
    else
    begin
      meta_r <= d;
      q <= meta_r;
    end
  end

endmodule

// ===== hdl/sfpi_top.v
/*
  Pin-level serial interface of a serial NOR flash: select, clock, hold
  and protect handling, single and dual data phases, pin direction.
  Assumes all pins are asynchronous to sys_clk and the serial clock is
  well below a sixth of sys_clk; command decoding sits outside and picks
  the phase of each following byte through phase_mode.
*/
`include "sfpi_consts.vh"

// Function
// R1 - Secondary pin drives output data, changing on falling serial clock edges.
// R2 - In dual-input program the secondary pin is an input sampled on rising edges.
// R3 - Commands, addresses and data on the primary pin sampled on rising edges.
// R4 - In dual-output read the primary pin also drives data on falling edges.
// R5 - Select high deselects the device and floats the secondary pin.
// R6 - Deselected and idle means standby; a running internal cycle keeps it active.
// R7 - Select low selects the device in active power mode, ready for input.
// R8 - Nothing is accepted before the first falling select edge after power-up.
// R9 - Hold low pauses transfer, floats the secondary pin, ignores clock and data.
// R10 - The master starts hold only while the device is selected.
// R11 - Protect input low freezes the three block-protect bits.
// R12 - Both clock idle levels work: low for mode 0, high for mode 3.
// R13 - Write-class commands accepted only if clock count is a multiple of eight.
// R14 - Each data pin floats unless the current phase needs the device to drive.
module sfpi_top #(
  parameter RX_DEPTH = `SFPI_RX_DEPTH,
  parameter RX_AW = `SFPI_RX_AW
) (
  input wire sys_clk, // System clock, 100 MHz
  input wire rst_b, // Synchronous reset, active low
  input wire sel_b, // Chip select pin, active low
  input wire sclk, // Serial clock pin
  input wire primary_data_pin_in, // Primary data pin, input level
  output reg primary_data_pin_out, // Primary data pin, driven level
  output reg primary_data_pin_oe, // Primary data pin, drive enable
  input wire secondary_data_pin_in, // Secondary data pin, input level
  output reg secondary_data_pin_out, // Secondary data pin, driven level
  output reg secondary_data_pin_oe, // Secondary data pin, drive enable
  input wire hold_b, // Hold pin, active low
  input wire wp_b, // Write protect pin, active low
  input wire busy, // Internal program, erase or status write running
  input wire [1:0] phase_mode, // Phase of the byte after the current one
  input wire wr_class, // Current command is program, erase or status write
  output wire [7:0] rx_data, // Received byte
  output wire rx_first, // Received byte is the command byte
  output wire rx_valid, // Received byte present
  input wire rx_ready, // Received byte taken
  input wire [7:0] tx_data, // Byte to shift out
  input wire tx_valid, // Byte to shift out offered
  output reg tx_ready, // Room for a byte to shift out
  input wire [2:0] bp_in, // New block-protect bits
  input wire bp_wr, // Write block-protect bits
  output reg [2:0] bp_bits, // Current block-protect bits
  output reg protect_frozen, // Block-protect bits are frozen
  output reg selected, // Device selected
  output reg power_active, // Active power mode
  output reg standby, // Standby power mode
  output reg write_accept, // Write-class command accepted, pulse
  output reg write_reject, // Write-class command rejected, pulse
  output reg overrun // Received byte lost to a full buffer
);

  wire [`SFPI_SYNC_W-1:0] pins_s;
  wire sel_s = pins_s[`SFPI_PIN_SEL];
  wire sclk_s = pins_s[`SFPI_PIN_SCLK];
  wire pri_s = pins_s[`SFPI_PIN_PRI];
  wire sec_s = pins_s[`SFPI_PIN_SEC];
  wire hold_s = pins_s[`SFPI_PIN_HOLD];
  wire wp_s = pins_s[`SFPI_PIN_WP];

  reg sclk_d_r;
  reg sel_d_r;
  reg armed_r;
  reg [1:0] mode_r;
  reg [3:0] bit_cnt_r;
  reg [2:0] clk_cnt_r;
  reg [2:0] out_cnt_r;
  reg out_on_r;
  reg [7:0] rx_sh_r;
  reg [7:0] tx_sh_r;
  reg first_r;
  reg [7:0] tx_buf_r;
  reg tx_full_r;
  reg wr_class_r;
  reg push_r;
  reg [`SFPI_RX_W-1:0] push_data_r;
  wire fifo_in_ready;
  wire [`SFPI_RX_W-1:0] fifo_out;

  function is_out_mode;
    input [1:0] m;
    begin
      is_out_mode = (m == `SFPI_MODE_SOUT) || (m == `SFPI_MODE_DOUT);
    end
  endfunction

  function is_dual_mode;
    input [1:0] m;
    begin
      is_dual_mode = (m == `SFPI_MODE_DOUT) || (m == `SFPI_MODE_DIN);
    end
  endfunction

  sfpi_sync #(
    .W(`SFPI_SYNC_W)
  ) u_sync (
    .sys_clk(sys_clk),
    .rst_b(rst_b),
    .d({wp_b, hold_b, secondary_data_pin_in, primary_data_pin_in, sclk, sel_b}),
    .q(pins_s)
  );

  // Edges found on the sampled clock; only edges matter, so idle level is free
  wire sclk_rise = sclk_s & ~sclk_d_r; // [R12]
  wire sclk_fall = ~sclk_s & sclk_d_r; // [R12]
  wire sel_fall = ~sel_s & sel_d_r;
  wire sel_rise = sel_s & ~sel_d_r;
  wire active = armed_r & ~sel_s; // [R7] [R8]
  wire running = active & hold_s; // [R9]
  wire go_rise = running & sclk_rise; // [R9]
  wire go_fall = running & sclk_fall; // [R9]
  wire [3:0] step = is_dual_mode(mode_r) ? 4'h2 : 4'h1;
  wire [3:0] bit_sum = bit_cnt_r + step;
  wire byte_done = go_rise && (bit_sum == `SFPI_BYTE_BITS);
  wire tx_take = tx_valid & tx_ready;
  wire [7:0] out_byte = tx_full_r ? tx_buf_r : `SFPI_TX_IDLE;
  wire out_load = go_fall && is_out_mode(mode_r) && (out_cnt_r == 3'h0);

  // Selection, edge history and power state
  always @(posedge sys_clk)
  begin
    if (!rst_b)
    begin
      sclk_d_r <= 1'b0;
      sel_d_r <= 1'b1;
      armed_r <= 1'b0;
      selected <= 1'b0;
      power_active <= 1'b0;
      standby <= 1'b1;
    end
    else
    begin
      sclk_d_r <= sclk_s;
      sel_d_r <= sel_s;
      if (sel_fall)
        armed_r <= 1'b1; // [R8]
      selected <= active; // [R7]
      power_active <= active | busy; // [R6] [R7]
      standby <= ~(active | busy); // [R6]
    end
  end

  // Bit and byte framing
  always @(posedge sys_clk)
  begin
    if (!rst_b)
    begin
      mode_r <= `SFPI_MODE_SIN;
      bit_cnt_r <= 4'h0;
      clk_cnt_r <= 3'h0;
      rx_sh_r <= 8'h00;
      first_r <= 1'b1;
      push_r <= 1'b0;
      push_data_r <= {`SFPI_RX_W{1'b0}};
    end
    else
    begin
      push_r <= 1'b0;
      if (sel_fall)
      begin
        // Every frame opens with a single-line command byte
        mode_r <= `SFPI_MODE_SIN;
        bit_cnt_r <= 4'h0;
        clk_cnt_r <= 3'h0;
        first_r <= 1'b1;
      end
      else if (go_rise)
      begin
        clk_cnt_r <= clk_cnt_r + 3'h1; // [R13]
        if (mode_r == `SFPI_MODE_SIN)
          rx_sh_r <= {rx_sh_r[6:0], pri_s}; // [R3]
        else if (mode_r == `SFPI_MODE_DIN)
          rx_sh_r <= {rx_sh_r[5:0], sec_s, pri_s}; // [R2]
        if (byte_done)
        begin
          bit_cnt_r <= 4'h0;
          mode_r <= phase_mode;
          first_r <= 1'b0;
          if (!is_out_mode(mode_r))
          begin
            push_r <= 1'b1;
            if (mode_r == `SFPI_MODE_SIN)
              push_data_r <= {first_r, rx_sh_r[6:0], pri_s}; // [R3]
            else
              push_data_r <= {first_r, rx_sh_r[5:0], sec_s, pri_s}; // [R2]
          end
        end
        else
          bit_cnt_r <= bit_sum;
      end
    end
  end

  // Output shifting on falling edges
  always @(posedge sys_clk)
  begin
    if (!rst_b)
    begin
      out_cnt_r <= 3'h0;
      out_on_r <= 1'b0;
      tx_sh_r <= 8'h00;
      primary_data_pin_out <= 1'b0;
      secondary_data_pin_out <= 1'b0;
    end
    else if (sel_fall || byte_done)
    begin
      out_cnt_r <= 3'h0;
      out_on_r <= 1'b0;
    end
    else if (go_fall && is_out_mode(mode_r))
    begin
      out_on_r <= 1'b1;
      out_cnt_r <= out_cnt_r + step[2:0];
      if (mode_r == `SFPI_MODE_DOUT)
      begin
        secondary_data_pin_out <= out_load ? out_byte[7] : tx_sh_r[7]; // [R4]
        primary_data_pin_out <= out_load ? out_byte[6] : tx_sh_r[6]; // [R4]
        tx_sh_r <= out_load ? {out_byte[5:0], 2'h0} : {tx_sh_r[5:0], 2'h0};
      end
      else
      begin
        secondary_data_pin_out <= out_load ? out_byte[7] : tx_sh_r[7]; // [R1]
        tx_sh_r <= out_load ? {out_byte[6:0], 1'b0} : {tx_sh_r[6:0], 1'b0};
      end
    end
  end

  // Pin direction, one cycle behind the phase state
  always @(posedge sys_clk)
  begin
    if (!rst_b)
    begin
      primary_data_pin_oe <= 1'b0;
      secondary_data_pin_oe <= 1'b0;
    end
    else
    begin
      // Drive only once the first output bit is out, never during input phases
      primary_data_pin_oe <= running && out_on_r
        && (mode_r == `SFPI_MODE_DOUT); // [R4] [R14] [R9]
      secondary_data_pin_oe <= running && out_on_r
        && is_out_mode(mode_r); // [R1] [R5] [R9] [R2] [R14]
    end
  end

  // Byte to shift out, one deep
  always @(posedge sys_clk)
  begin
    if (!rst_b)
    begin
      tx_buf_r <= 8'h00;
      tx_full_r <= 1'b0;
      tx_ready <= 1'b0;
    end
    else
    begin
      if (tx_take)
        tx_buf_r <= tx_data;
      // An offer taken in the cycle the idle byte is loaded is kept
      if (tx_take)
        tx_full_r <= 1'b1;
      else if (out_load)
        tx_full_r <= 1'b0;
      tx_ready <= ~(tx_take | (tx_full_r & ~out_load));
    end
  end

  // Write-class length check, protect bits, overrun
  always @(posedge sys_clk)
  begin
    if (!rst_b)
    begin
      wr_class_r <= 1'b0;
      write_accept <= 1'b0;
      write_reject <= 1'b0;
      bp_bits <= `SFPI_BP_RST;
      protect_frozen <= 1'b0;
      overrun <= 1'b0;
    end
    else
    begin
      write_accept <= 1'b0;
      write_reject <= 1'b0;
      if (sel_fall)
        wr_class_r <= 1'b0;
      else if (active && wr_class)
        wr_class_r <= 1'b1;
      if (sel_rise && armed_r && wr_class_r)
      begin
        write_accept <= (clk_cnt_r == 3'h0); // [R13]
        write_reject <= (clk_cnt_r != 3'h0); // [R13]
      end
      protect_frozen <= ~wp_s; // [R11]
      if (bp_wr && wp_s)
        bp_bits <= bp_in; // [R11]
      // A loss in the opening cycle of a frame still counts
      if (push_r && !fifo_in_ready)
        overrun <= 1'b1;
      else if (sel_fall)
        overrun <= 1'b0;
    end
  end

  // The serial master cannot be stalled, so a full buffer drops and flags
  sfpi_fifo #(
    .W(`SFPI_RX_W),
    .DEPTH(RX_DEPTH),
    .AW(RX_AW)
  ) u_rx_fifo (
    .sys_clk(sys_clk),
    .rst_b(rst_b),
    .in_data(push_data_r),
    .in_valid(push_r),
    .in_ready(fifo_in_ready),
    .out_data(fifo_out),
    .out_valid(rx_valid),
    .out_ready(rx_ready)
  );

  assign rx_data = fifo_out[7:0];
  assign rx_first = fifo_out[8];

endmodule

// ===== test/serial_flash_pin_interface_test.sv
/*
  Self-checking bench for sfpi_top with a master model on the pins.
  Assumes the receive buffer is 32 deep and one transmit byte is held.
*/
`include "sfpi_consts.vh"
`define CHK(g, e) check_val(g, e)
module serial_flash_pin_interface_test;
  timeunit 1ns;
  timeprecision 100ps;
  logic sys_clk = 1'b0, rst_b = 1'b0, wp_b = 1'b1, busy = 1'b0, wr_class = 1'b0;
  logic rx_ready = 1'b0, tx_valid = 1'b0, bp_wr = 1'b0;
  logic [1:0] phase_mode = `SFPI_MODE_SIN;
  logic [7:0] tx_data = 8'h00, d, r, r2;
  logic [2:0] bp_in = 3'h0;
  wire sel_b, sclk, hold_b, m_pri, m_sec, primary_data_pin_out, primary_data_pin_oe;
  wire secondary_data_pin_out, secondary_data_pin_oe, rx_first, rx_valid, tx_ready;
  wire protect_frozen, selected, power_active, standby, write_accept, write_reject, overrun;
  wire [7:0] rx_data;
  wire [2:0] bp_bits;
  wire primary_data_pin_in = primary_data_pin_oe ? primary_data_pin_out : m_pri;
  wire secondary_data_pin_in = secondary_data_pin_oe ? secondary_data_pin_out : m_sec;
  int n_mismatch = 0, check_count = 0, n_acc = 0, n_rej = 0, i, k;
  logic [8:0] exp_q[$];
  sfpi_top uut (.sys_clk, .rst_b, .sel_b, .sclk, .primary_data_pin_in, .primary_data_pin_out,
    .primary_data_pin_oe, .secondary_data_pin_in, .secondary_data_pin_out, .secondary_data_pin_oe,
    .hold_b, .wp_b, .busy, .phase_mode, .wr_class, .rx_data, .rx_first, .rx_valid, .rx_ready,
    .tx_data, .tx_valid, .tx_ready, .bp_in, .bp_wr, .bp_bits, .protect_frozen, .selected,
    .power_active, .standby, .write_accept, .write_reject, .overrun);
  sfpi_master mst (.sel_b, .sclk, .hold_b, .pri_drv(m_pri), .sec_drv(m_sec),
    .pri_pin(primary_data_pin_in), .sec_pin(secondary_data_pin_in));
  initial forever #5 sys_clk = ~sys_clk;
  always @(posedge sys_clk)
  begin
    if (write_accept === 1'b1) n_acc++;
    if (write_reject === 1'b1) n_rej++;
  end
  task check_val(input logic [31:0] g, input logic [31:0] e);
    check_count++;
    if (g !== e)
    begin
      n_mismatch++;
      $display("mismatch at %0t: got %h expected %h", $time, g, e);
    end
  endtask
  task summarize;
    if (n_mismatch == 0 && check_count > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  task tick(input int n);
    repeat (n) @(posedge sys_clk);
    #1;
  endtask
  task hang;
    n_mismatch++;
    summarize;
  endtask
  task send(input logic [7:0] b, input bit first, input bit dual);
    mst.xfer(dual ? 4 : 8, dual, 1, b, r);
    exp_q.push_back({first, b});
  endtask
  task drain;
    while (exp_q.size() > 0)
    begin
      for (k = 0; k < 300 && rx_valid !== 1'b1; k++) tick(1);
      if (k == 300) hang;
      `CHK(rx_data, exp_q[0][7:0]);
      `CHK(rx_first, exp_q[0][8]);
      void'(exp_q.pop_front());
      rx_ready = 1'b1;
      tick(1);
      rx_ready = 1'b0;
      tick(1);
    end
  endtask
  initial #900us hang;
  initial
  begin
    void'($urandom(41651));
    tick(20);
    `CHK(standby, 1'b1);
    `CHK(secondary_data_pin_oe, 1'b0);
    rst_b = 1'b1;
    tick(3);
    // Buffer filled past its depth while nothing is taken
    mst.start_frame(0);
    send(8'($urandom), 1, 0);
    for (i = 1; i < 33; i++) send(8'($urandom), 0, 0);
    mst.stop_frame;
    void'(exp_q.pop_back());
    `CHK(overrun, 1'b1);
    drain;
    tick(5);
    `CHK(rx_valid, 1'b0);
    // Dual input in mode 3 with a hold in mid-byte
    phase_mode = `SFPI_MODE_DIN;
    mst.start_frame(1);
    `CHK(selected, 1'b1);
    send(8'($urandom), 1, 0);
    d = 8'($urandom);
    mst.xfer(2, 1, 1, d, r);
    mst.pause(8'($urandom));
    mst.xfer(2, 1, 1, d << 4, r);
    exp_q.push_back({1'b0, d});
    mst.stop_frame;
    drain;
    // Single out in mode 3, dual out in mode 0
    for (i = 0; i < 2; i++)
    begin
      phase_mode = i ? `SFPI_MODE_DOUT : `SFPI_MODE_SOUT;
      d = 8'($urandom);
      tx_data = d;
      tx_valid = 1'b1;
      for (k = 0; k < 100 && tx_ready !== 1'b1; k++) tick(1);
      if (k == 100) hang;
      tick(1);
      tx_valid = 1'b0;
      mst.start_frame(i == 0);
      send(8'($urandom), 1, 0);
      // Hold in mid-byte: pins float, shifting resumes where it stopped
      mst.xfer(i ? 2 : 4, i, 0, 8'h00, r);
      mst.pause(8'($urandom));
      mst.xfer(i ? 2 : 4, i, 0, 8'h00, r2);
      mst.stop_frame;
      `CHK({r[3:0], r2[3:0]}, d);
      drain;
    end
    // Whole byte then four spare clocks with a write-class command
    phase_mode = `SFPI_MODE_SIN;
    wr_class = 1'b1;
    for (i = 0; i < 2; i++)
    begin
      mst.start_frame(0);
      send(8'($urandom), 1, 0);
      if (i == 0) send(8'($urandom), 0, 0);
      else mst.xfer(4, 0, 1, 8'($urandom), r);
      mst.stop_frame;
      drain;
    end
    wr_class = 1'b0;
    `CHK(n_acc, 1);
    `CHK(n_rej, 1);
    busy = 1'b1;
    tick(4);
    `CHK(power_active, 1'b1);
    `CHK(standby, 1'b0);
    busy = 1'b0;
    tick(4);
    `CHK(standby, 1'b1);
    for (i = 0; i < 2; i++)
    begin
      wp_b = i[0];
      tick(6);
      bp_in = 3'h5;
      bp_wr = 1'b1;
      tick(1);
      bp_wr = 1'b0;
      tick(2);
      `CHK(bp_bits, i ? 3'h5 : 3'h0);
      `CHK(protect_frozen, !i[0]);
    end
    summarize;
  end
endmodule

// ===== test/sfpi_master.sv
/*
  Bus master model: select, serial clock, hold and both data wires.
  Assumes the bench resolves each wire from the design's enable first.
*/
module sfpi_master (
  output logic sel_b, // Select, active low
  output logic sclk, // Serial clock, 125 ns
  output logic hold_b, // Hold, active low
  output logic pri_drv, // Primary level offered
  output logic sec_drv, // Secondary level offered
  input wire logic pri_pin, // Primary wire
  input wire logic sec_pin // Secondary wire
);
  timeunit 1ns;
  timeprecision 100ps;
  bit cpol = 1'b0;
  initial
  begin
    sel_b = 1'b1;
    sclk = 1'b0;
    hold_b = 1'b1;
    pri_drv = 1'b0;
    sec_drv = 1'b0;
  end
  task start_frame(input bit mode3);
    cpol = mode3;
    sclk = mode3;
    #100 sel_b = 1'b0;
    #100;
  endtask
  task stop_frame;
    sclk = cpol;
    #100 sel_b = 1'b1;
    #400;
  endtask
  // Released wires toggle so a floating read never looks valid
  task xfer(input int n, input bit dual, input bit drv, input logic [7:0] din,
    output logic [7:0] dout);
    logic [7:0] sh;
    sh = din;
    dout = 8'h00;
    repeat (n)
    begin
      sclk = 1'b0;
      if (drv && dual)
        {sec_drv, pri_drv} = sh[7:6];
      else if (drv)
      begin
        pri_drv = sh[7];
        sec_drv = ~sec_drv;
      end
      else
        {sec_drv, pri_drv} = ~{sec_drv, pri_drv};
      sh = dual ? sh << 2 : sh << 1;
      #62.5 sclk = 1'b1;
      dout = dual ? {dout[5:0], sec_pin, pri_pin} : {dout[6:0], sec_pin};
      #62.5;
    end
    sclk = cpol;
  endtask
  task pause(input logic [7:0] junk);
    logic [7:0] d;
    if (!sel_b)
    begin
      // Let the trailing mode 0 falling edge be seen before the pause
      #100 hold_b = 1'b0;
      #100 xfer(4, 0, 1, junk, d);
      #100 hold_b = 1'b1;
      #100;
    end
  endtask
endmodule

// ===== test/sfpi_top_properties.sv
/*
  Concurrent checks on the pins and status outputs of sfpi_top.
  Assumes the serial clock stays at one level for at least six sys_clk.
*/
module sfpi_top_properties (
  input wire sys_clk, // Clock
  input wire rst_b, // Reset
  input wire sel_b, // Select pin
  input wire sclk, // Serial clock pin
  input wire hold_b, // Hold pin
  input wire wp_b, // Protect pin
  input wire busy, // Internal cycle
  input wire bp_wr, // Protect write
  input wire primary_data_pin_out, // Primary out
  input wire primary_data_pin_oe, // Primary enable
  input wire secondary_data_pin_out, // Secondary out
  input wire secondary_data_pin_oe, // Secondary enable
  input wire [2:0] bp_bits, // Protect bits
  input wire protect_frozen, // Frozen flag
  input wire selected, // Selected
  input wire power_active, // Active power
  input wire standby, // Standby
  input wire write_accept, // Accept pulse
  input wire write_reject // Reject pulse
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_b);
  property p_sec_float; sel_b [*8] |-> !secondary_data_pin_oe; endproperty
  a_sec_float: assert property (p_sec_float) else $error("secondary pin driven while deselected");
  property p_hold_float; (!hold_b && !sel_b) [*8] |-> !secondary_data_pin_oe && !primary_data_pin_oe;
  endproperty
  a_hold_float: assert property (p_hold_float) else $error("pin driven during hold");
  property p_standby; (!busy && sel_b) [*8] |-> standby && !power_active; endproperty
  a_standby: assert property (p_standby) else $error("no standby when idle");
  property p_busy_active; busy [*3] |-> power_active && !standby; endproperty
  a_busy_active: assert property (p_busy_active) else $error("not active while busy");
  property p_select; $fell(sel_b) |-> ##[2:8] selected; endproperty
  a_select: assert property (p_select) else $error("select fall not seen");
  property p_deselect; $rose(sel_b) |-> ##[2:8] !selected; endproperty
  a_deselect: assert property (p_deselect) else $error("select rise not seen");
  property p_wr_pulse; (write_accept || write_reject) |-> sel_b && $past(sel_b, 3)
    && !(write_accept && write_reject) ##1 !(write_accept || write_reject); endproperty
  a_wr_pulse: assert property (p_wr_pulse) else $error("bad length check pulse");
  property p_sec_fall; secondary_data_pin_oe && $past(secondary_data_pin_oe)
    && $changed(secondary_data_pin_out) |-> !$past(sclk, 2); endproperty
  a_sec_fall: assert property (p_sec_fall) else $error("secondary changed off falling edge");
  property p_pri_fall; primary_data_pin_oe && $past(primary_data_pin_oe)
    && $changed(primary_data_pin_out) |-> !$past(sclk, 2); endproperty
  a_pri_fall: assert property (p_pri_fall) else $error("primary changed off falling edge");
  property p_frozen; (!wp_b) [*4] |-> protect_frozen; endproperty
  a_frozen: assert property (p_frozen) else $error("protect not frozen");
  property p_bp_hold; (!wp_b) [*5] ##0 bp_wr |=> $stable(bp_bits); endproperty
  a_bp_hold: assert property (p_bp_hold) else $error("protect bits changed while frozen");
endmodule

bind sfpi_top sfpi_top_properties chk (.sys_clk, .rst_b, .sel_b, .sclk, .hold_b, .wp_b, .busy,
  .bp_wr, .primary_data_pin_out, .primary_data_pin_oe, .secondary_data_pin_out,
  .secondary_data_pin_oe, .bp_bits, .protect_frozen, .selected, .power_active, .standby,
  .write_accept, .write_reject);
